// file: src/vic_defines.vh
// Constants of the vectored interrupt controller: map, fields, resets, timing
`ifndef VIC_DEFINES_VH
`define VIC_DEFINES_VH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define VIC_NUM_SRC 118
`define VIC_NUM_TRAP 6
`define VIC_SRC_VEC_OFS 8'h08
`define VIC_TRAP_CODES 18'h34688

// ----------------------------------------------------------------
// Program memory addresses
// ----------------------------------------------------------------
`define VIC_IVT_BASE 24'h000004
`define VIC_ALTERNATE_VECTOR_TABLE_BASE 24'h000104
`define VIC_RESET_PC 24'h000000

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define VIC_OFS_STATUS 12'h000
`define VIC_OFS_CTRL2 12'h004
`define VIC_OFS_EVT_STAT 12'h008
`define VIC_OFS_EVT_CLR 12'h00c
`define VIC_OFS_EVT_EN 12'h010
`define VIC_OFS_FLAG_BASE 12'h040
`define VIC_OFS_FLAG_END 12'h060
`define VIC_OFS_EN_BASE 12'h060
`define VIC_OFS_EN_END 12'h080
`define VIC_OFS_PRIO_BASE 12'h080
`define VIC_OFS_PRIO_END 12'h0f8
`define VIC_OFS_VEC_TOP 2'h1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VIC_BIT_CORE_REQUEST_UNACKED 15
`define VIC_BIT_HOLD 13
`define VIC_BIT_ALT 8
`define VIC_EVT_ENTRY 0
`define VIC_EVT_RETURN 1
`define VIC_EVT_RAISE 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define VIC_RST_HOLD 1'h0
`define VIC_RST_ALT 1'h0
`define VIC_RST_EVT 3'h0
`define VIC_RST_VEC 8'h00
`define VIC_RST_LVL 4'h0

// ----------------------------------------------------------------
// Timing in REF_CLK cycles
// ----------------------------------------------------------------
`define VIC_ENTRY_CYC 4'h5
`define VIC_RETURN_CYC 4'h3

`endif

// file: src/vic_top.v
// Vectored interrupt controller with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "vic_defines.vh"
module vic_top (
    input wire REF_CLK,
    input wire RST_N,
    input wire CE,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output wire [31:0] HRDATA,
    output wire HREADYOUT,
    output wire HRESP,
    input wire [117:0] SRC_REQ,
    input wire [5:0] TRAP_REQ,
    input wire [3:0] CPU_PRIORITY,
    input wire CORE_ACK,
    input wire CORE_RETURN,
    output wire CORE_IRQ,
    output wire [7:0] CORE_VECTOR,
    output wire [3:0] CORE_LEVEL,
    output wire [23:0] CORE_VEC_ADDR,
    output wire [23:0] CORE_PC,
    output wire CORE_PC_LOAD,
    output wire CORE_RETURN_DONE,
    output wire EVT_IRQ
);
    localparam ST_IDLE = 3'd0;
    localparam ST_FETCH = 3'd1;
    localparam ST_REQ = 3'd2;
    localparam ST_ENTRY = 3'd3;
    localparam ST_RET = 3'd4;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [2:0] state_r;
    reg [3:0] cnt_r;
    reg [117:0] flag_r;
    reg [117:0] en_r;
    reg [353:0] prio_r;
    reg [5:0] trap_r;
    reg hold_r;
    reg alt_r;
    reg [2:0] evt_r;
    reg [2:0] evt_en_r;
    reg evt_irq_r;
    reg ret_pend_r;
    reg [7:0] pres_vec_r;
    reg [3:0] pres_lvl_r;
    reg [23:0] vec_addr_r;
    reg [23:0] pc_r;
    reg pc_load_r;
    reg ret_done_r;
    reg core_irq_r;
    reg wr_pend_r;
    reg [11:0] wa_r;
    reg rd_go_r;
    reg [11:0] ra_r;
    reg hready_r;
    reg [31:0] hrdata_r;

    wire [23:0] mem_rdata;
    wire accept = HSEL && HTRANS[1] && HREADY;
    wire wr_en = wr_pend_r;
    wire wr_status = wr_en && (wa_r == `VIC_OFS_STATUS);
    wire wr_ctrl2 = wr_en && (wa_r == `VIC_OFS_CTRL2);
    wire wr_evt_clr = wr_en && (wa_r == `VIC_OFS_EVT_CLR);
    wire wr_evt_en = wr_en && (wa_r == `VIC_OFS_EVT_EN);
    wire wr_flag = wr_en && (wa_r >= `VIC_OFS_FLAG_BASE) && (wa_r < `VIC_OFS_FLAG_END);
    wire wr_enw = wr_en && (wa_r >= `VIC_OFS_EN_BASE) && (wa_r < `VIC_OFS_EN_END);
    wire wr_prio = wr_en && (wa_r >= `VIC_OFS_PRIO_BASE) && (wa_r < `VIC_OFS_PRIO_END);
    wire wr_vec = wr_en && (wa_r[11:10] == `VIC_OFS_VEC_TOP);
    wire [11:0] wp_idx = (wa_r - `VIC_OFS_PRIO_BASE) >> 2;
    wire [11:0] rp_idx = (ra_r - `VIC_OFS_PRIO_BASE) >> 2;

    // ----------------------------------------------------------------
    // Arbitration
    // ----------------------------------------------------------------
    reg found;
    reg [7:0] best_v;
    reg [3:0] best_l;
    reg [3:0] lvl;
    reg [2:0] code;
    reg [31:0] vtmp;
    integer i, j, k;
    wire [17:0] trap_codes = `VIC_TRAP_CODES;

    always @* begin
        found = 1'b0;
        best_v = `VIC_RST_VEC;
        best_l = `VIC_RST_LVL;
        lvl = 4'h0;
        code = 3'h0;
        vtmp = 32'h0;
        // Traps have no enable bit and sit above every user level; CPU_PRIORITY still masks them
        for (i = 0; i < `VIC_NUM_TRAP; i = i + 1) begin
            code = trap_codes[3 * i +: 3];
            lvl = 4'hf - {1'b0, code};
            if (trap_r[i] && (lvl > best_l)) begin
                found = 1'b1;
                best_l = lvl;
                best_v = {5'h00, code};
            end
        end
        for (i = 0; i < `VIC_NUM_SRC; i = i + 1) begin
            lvl = {1'b0, prio_r[3 * i +: 3]};
            // Strict compare keeps the lower vector on a tie
            if (flag_r[i] && en_r[i] && (lvl != 4'h0) && (lvl > best_l)) begin
                found = 1'b1;
                best_l = lvl;
                vtmp = i;
                best_v = vtmp[7:0] + `VIC_SRC_VEC_OFS;
            end
        end
    end

    wire can_raise = found && (best_l > CPU_PRIORITY);
    wire core_request_unacked = found && (best_l <= CPU_PRIORITY);
    wire [7:0] stat_vec = hold_r ? best_v : pres_vec_r;
    wire [3:0] stat_lvl = hold_r ? best_l : pres_lvl_r;
    wire start_fetch = (state_r == ST_IDLE) && !ret_pend_r && can_raise;
    wire ack_take = (state_r == ST_REQ) && CORE_ACK;
    wire [23:0] tbl_base = alt_r ? `VIC_ALTERNATE_VECTOR_TABLE_BASE : `VIC_IVT_BASE;

    // ----------------------------------------------------------------
    // Vector table
    // ----------------------------------------------------------------
    // Same index layout for both tables; the top bit picks the table
    vic_vector_mem u_mem (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .ce(CE),
        .we(wr_vec),
        .waddr(wa_r[9:2]),
        .wdata(HWDATA[23:0]),
        .re(start_fetch),
        .raddr({alt_r, best_v[6:0]}),
        .rdata(mem_rdata)
    );

    // ----------------------------------------------------------------
    // Flags, enables, priorities
    // ----------------------------------------------------------------
    reg [117:0] flag_nxt;
    reg [117:0] en_nxt;
    reg [353:0] prio_nxt;
    reg [5:0] trap_nxt;
    reg ack_hit;

    always @* begin
        flag_nxt = flag_r;
        en_nxt = en_r;
        prio_nxt = prio_r;
        trap_nxt = trap_r;
        ack_hit = 1'b0;
        for (j = 0; j < `VIC_NUM_SRC; j = j + 1) begin
            // Word j/16, bit j%16: source 106 lands in word 6 bit 10
            if (wr_flag && (wa_r[4:2] == j / 16)) begin
                flag_nxt[j] = HWDATA[j % 16];
            end
            if (wr_enw && (wa_r[4:2] == j / 16)) begin
                en_nxt[j] = HWDATA[j % 16];
            end
            if (wr_prio && (wp_idx == j / 4)) begin
                prio_nxt[3 * j +: 3] = HWDATA[(j % 4) * 4 +: 3];
            end
            ack_hit = ack_take && ({24'h000000, pres_vec_r} == j + 8);
            // New request wins over a clear in the same cycle
            flag_nxt[j] = (flag_nxt[j] & ~ack_hit) | SRC_REQ[j];
        end
        for (j = 0; j < `VIC_NUM_TRAP; j = j + 1) begin
            ack_hit = ack_take && (pres_vec_r[2:0] == trap_codes[3 * j +: 3])
                && (pres_vec_r[7:3] == 5'h00);
            trap_nxt[j] = (trap_r[j] & ~ack_hit) | TRAP_REQ[j];
        end
    end

    // ----------------------------------------------------------------
    // Control, flags and events
    // ----------------------------------------------------------------
    wire [2:0] evt_set = {start_fetch, ret_done_r, pc_load_r};
    wire [2:0] evt_clr = wr_evt_clr ? HWDATA[2:0] : 3'h0;
    wire [2:0] evt_nxt = (evt_r & ~evt_clr) | evt_set;

    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            flag_r <= {`VIC_NUM_SRC{1'b0}};
            en_r <= {`VIC_NUM_SRC{1'b0}};
            prio_r <= {354{1'b0}};
            trap_r <= 6'h00;
            hold_r <= `VIC_RST_HOLD;
            alt_r <= `VIC_RST_ALT;
            evt_r <= `VIC_RST_EVT;
            evt_en_r <= `VIC_RST_EVT;
            evt_irq_r <= 1'b0;
        end else if (CE) begin
            flag_r <= flag_nxt;
            en_r <= en_nxt;
            prio_r <= prio_nxt;
            trap_r <= trap_nxt;
            if (wr_status) begin
                hold_r <= HWDATA[`VIC_BIT_HOLD];
            end
            if (wr_ctrl2) begin
                alt_r <= HWDATA[`VIC_BIT_ALT];
            end
            if (wr_evt_en) begin
                evt_en_r <= HWDATA[2:0];
            end
            evt_r <= evt_nxt;
            evt_irq_r <= |(evt_nxt & (wr_evt_en ? HWDATA[2:0] : evt_en_r));
        end
    end

    // ----------------------------------------------------------------
    // Entry and return sequencer
    // ----------------------------------------------------------------
    // Counts are constant so latency never depends on the source
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            ret_pend_r <= 1'b0;
            pres_vec_r <= `VIC_RST_VEC;
            pres_lvl_r <= `VIC_RST_LVL;
            vec_addr_r <= `VIC_RESET_PC;
            pc_r <= `VIC_RESET_PC;
            pc_load_r <= 1'b0;
            ret_done_r <= 1'b0;
            core_irq_r <= 1'b0;
        end else if (CE) begin
            pc_load_r <= 1'b0;
            ret_done_r <= 1'b0;
            if (CORE_RETURN) begin
                ret_pend_r <= 1'b1;
            end
            case (state_r)
                ST_IDLE: begin
                    if (ret_pend_r) begin
                        ret_pend_r <= CORE_RETURN;
                        cnt_r <= `VIC_RETURN_CYC - 4'h1;
                        state_r <= ST_RET;
                    end else if (can_raise) begin
                        pres_vec_r <= best_v;
                        pres_lvl_r <= best_l;
                        vec_addr_r <= tbl_base + {15'h0000, best_v, 1'b0};
                        state_r <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    pc_r <= mem_rdata;
                    core_irq_r <= 1'b1;
                    state_r <= ST_REQ;
                end
                ST_REQ: begin
                    if (CORE_ACK) begin
                        core_irq_r <= 1'b0;
                        cnt_r <= `VIC_ENTRY_CYC - 4'h1;
                        state_r <= ST_ENTRY;
                    end
                end
                ST_ENTRY: begin
                    if (cnt_r == 4'h0) begin
                        pc_load_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                ST_RET: begin
                    if (cnt_r == 4'h0) begin
                        ret_done_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    // Reads take one wait state so a write just ahead is always seen
    reg [31:0] rd_val;
    reg [15:0] w16;

    always @* begin
        rd_val = 32'h0;
        w16 = 16'h0;
        for (k = 0; k < `VIC_NUM_SRC; k = k + 1) begin
            if ((ra_r >= `VIC_OFS_FLAG_BASE) && (ra_r < `VIC_OFS_FLAG_END) && (ra_r[4:2] == k / 16)) begin
                w16[k % 16] = flag_r[k];
            end
            if ((ra_r >= `VIC_OFS_EN_BASE) && (ra_r < `VIC_OFS_EN_END) && (ra_r[4:2] == k / 16)) begin
                w16[k % 16] = en_r[k];
            end
            if ((ra_r >= `VIC_OFS_PRIO_BASE) && (ra_r < `VIC_OFS_PRIO_END) && (rp_idx == k / 4)) begin
                w16[(k % 4) * 4 +: 3] = prio_r[3 * k +: 3];
            end
        end
        if (ra_r == `VIC_OFS_STATUS) begin
            rd_val = {16'h0000, core_request_unacked, 1'b0, hold_r, 1'b0, stat_lvl, stat_vec};
        end else if (ra_r == `VIC_OFS_CTRL2) begin
            rd_val = {23'h000000, alt_r, 8'h00};
        end else if (ra_r == `VIC_OFS_EVT_STAT) begin
            rd_val = {29'h00000000, evt_r};
        end else if (ra_r == `VIC_OFS_EVT_EN) begin
            rd_val = {29'h00000000, evt_en_r};
        end else begin
            rd_val = {16'h0000, w16};
        end
    end

    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend_r <= 1'b0;
            wa_r <= 12'h000;
            rd_go_r <= 1'b0;
            ra_r <= 12'h000;
            hready_r <= 1'b1;
            hrdata_r <= 32'h00000000;
        end else if (CE) begin
            wr_pend_r <= accept && HWRITE;
            if (accept && HWRITE) begin
                wa_r <= HADDR[11:0];
            end
            if (accept && !HWRITE) begin
                ra_r <= HADDR[11:0];
                rd_go_r <= 1'b1;
                hready_r <= 1'b0;
            end else if (rd_go_r) begin
                rd_go_r <= 1'b0;
                hready_r <= 1'b1;
                hrdata_r <= rd_val;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign HRDATA = hrdata_r;
    assign HREADYOUT = hready_r;
    assign HRESP = 1'b0;
    assign CORE_IRQ = core_irq_r;
    assign CORE_VECTOR = pres_vec_r;
    assign CORE_LEVEL = pres_lvl_r;
    assign CORE_VEC_ADDR = vec_addr_r;
    assign CORE_PC = pc_r;
    assign CORE_PC_LOAD = pc_load_r;
    assign CORE_RETURN_DONE = ret_done_r;
    assign EVT_IRQ = evt_irq_r;
endmodule // vic_top
`default_nettype wire

// file: src/vic_vector_mem.v
// Dual-port vector table memory, both tables, registered read data
`timescale 1ns/1ps
`default_nettype none
module vic_vector_mem (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire we,
    input wire [7:0] waddr,
    input wire [23:0] wdata,
    input wire re,
    input wire [7:0] raddr,
    output reg [23:0] rdata
);
    reg [23:0] mem [0:255];

    always @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 24'h000000;
        end else if (ce && re) begin
            rdata <= mem[raddr];
        end
    end
endmodule // vic_vector_mem
`default_nettype wire

// file: test/test_vectored_interrupt_controller.sv
// Self-checking bench of the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module test_vectored_interrupt_controller;
    logic REF_CLK, RST_N, HSEL, HWRITE, CORE_RETURN, HREADYOUT, HRESP, CORE_IRQ, CORE_ACK;
    logic CORE_PC_LOAD, CORE_RETURN_DONE, EVT_IRQ;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0] HTRANS;
    logic [117:0] SRC_REQ;
    logic [5:0] TRAP_REQ;
    logic [3:0] CPU_PRIORITY, CORE_LEVEL, ack_dly;
    logic [7:0] CORE_VECTOR;
    logic [23:0] CORE_VEC_ADDR, CORE_PC, pc_taken;
    int err_total, n_checks, lat_ref, ret_ref;
    int cyc = 0;
    localparam logic [117:0] S0 = 118'h1, S1 = 118'h2, S106 = 118'h1 << 106;
    vic_top i_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(1'b1), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SRC_REQ(SRC_REQ), .TRAP_REQ(TRAP_REQ),
        .CPU_PRIORITY(CPU_PRIORITY), .CORE_ACK(CORE_ACK), .CORE_RETURN(CORE_RETURN), .CORE_IRQ(CORE_IRQ),
        .CORE_VECTOR(CORE_VECTOR), .CORE_LEVEL(CORE_LEVEL), .CORE_VEC_ADDR(CORE_VEC_ADDR), .CORE_PC(CORE_PC),
        .CORE_PC_LOAD(CORE_PC_LOAD), .CORE_RETURN_DONE(CORE_RETURN_DONE), .EVT_IRQ(EVT_IRQ));
    vic_core_model u_core (.clk(REF_CLK), .rst_n(RST_N), .irq(CORE_IRQ), .pc_load(CORE_PC_LOAD),
        .pc(CORE_PC), .dly(ack_dly), .ack(CORE_ACK), .pc_taken(pc_taken));
    // ----------------------------------------
    // Bus, compare and core tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        HSEL <= 1'b1; HADDR <= a; HWRITE <= w; HTRANS <= 2'h2;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= d;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask
    task automatic fire(input logic [117:0] s, input logic [5:0] t);
        SRC_REQ <= s; TRAP_REQ <= t;
        @(posedge REF_CLK);
        SRC_REQ <= '0; TRAP_REQ <= 6'h0;
    endtask
    task automatic serve(input logic [7:0] v, input logic [23:0] a, input logic [23:0] pc);
        int n;
        n = 0;
        while (CORE_IRQ !== 1'b1 && n < 40) begin @(posedge REF_CLK); n++; end
        chk({24'h0, CORE_VECTOR}, {24'h0, v});
        chk({8'h0, CORE_VEC_ADDR}, {8'h0, a});
        chk({8'h0, CORE_PC}, {8'h0, pc});
        while (CORE_ACK !== 1'b1) @(posedge REF_CLK);
        n = 0;
        while (CORE_PC_LOAD !== 1'b1 && n < 20) begin @(posedge REF_CLK); n++; end
        chk(n, lat_ref);
        @(posedge REF_CLK);
        chk({8'h0, pc_taken}, {8'h0, pc});
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk({8'h0, CORE_PC}, 32'h0);
        rdc(32'h000, 32'h0);
        rdc(32'h004, 32'h0);
        rdc(32'h300, 32'h0);
        rdc(32'h400, 32'h0);
    endtask
    task automatic t_setup;
        wr(32'h400, 32'h200); wr(32'h418, 32'h260); wr(32'h420, 32'h300);
        wr(32'h424, 32'h310); wr(32'h5c8, 32'h400); wr(32'h7c8, 32'h500);
        wr(32'h620, 32'h300);
        wr(32'h404, 32'h2f0);
        wr(32'h080, 32'h23); wr(32'h0e8, 32'h300); wr(32'h060, 32'h3); wr(32'h078, 32'h400);
        rdc(32'h078, 32'h400);
    endtask
    task automatic t_order;
        fire(S0 | S106, 6'h0);
        serve(8'h08, 24'h14, 24'h300);
        serve(8'h72, 24'he8, 24'h400);
        ack_dly <= 4'h3;
        fire(S1 | S106, 6'h0);
        serve(8'h72, 24'he8, 24'h400);
        serve(8'h09, 24'h16, 24'h310);
        fire(S0, 6'h1);
        serve(8'h00, 24'h04, 24'h200);
        serve(8'h08, 24'h14, 24'h300);
        fire('0, 6'h20);
        serve(8'h06, 24'h10, 24'h260);
        fire('0, 6'h2);
        serve(8'h01, 24'h06, 24'h2f0);
    endtask
    task automatic t_block;
        CPU_PRIORITY <= 4'h3;
        fire(S0, 6'h0);
        repeat (6) @(posedge REF_CLK);
        chk({31'h0, CORE_IRQ}, 32'h0);
        wr(32'h000, 32'h2000);
        rdc(32'h000, 32'ha308);
        CPU_PRIORITY <= 4'h0;
        serve(8'h08, 24'h14, 24'h300);
    endtask
    task automatic t_alt;
        wr(32'h004, 32'h100);
        rdc(32'h004, 32'h100);
        fire(S106, 6'h0);
        serve(8'h72, 24'h1e8, 24'h500);
        wr(32'h004, 32'h0);
    endtask
    task automatic t_evt;
        int n;
        wr(32'h00c, 32'h7); wr(32'h010, 32'h2);
        repeat (2) begin
            CORE_RETURN <= 1'b1;
            @(posedge REF_CLK);
            CORE_RETURN <= 1'b0;
            n = 0;
            while (CORE_RETURN_DONE !== 1'b1 && n < 20) begin @(posedge REF_CLK); n++; end
            chk(n, ret_ref);
        end
        repeat (2) @(posedge REF_CLK);
        chk({31'h0, EVT_IRQ}, 32'h1);
        rdc(32'h008, 32'h2);
        wr(32'h010, 32'h0);
        repeat (2) @(posedge REF_CLK);
        chk({31'h0, EVT_IRQ}, 32'h0);
        wr(32'h010, 32'h2); wr(32'h00c, 32'h2);
        repeat (2) @(posedge REF_CLK);
        chk({31'h0, EVT_IRQ}, 32'h0);
        rdc(32'h008, 32'h0);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        REF_CLK = 1'b0;
        forever #50 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            finish_test;
        end
    end
    initial begin
        RST_N = 1'b0; HSEL = 1'b0; HADDR = 32'h0; HTRANS = 2'h0; HWRITE = 1'b0; HWDATA = 32'h0;
        SRC_REQ = '0; TRAP_REQ = 6'h0; CPU_PRIORITY = 4'h0; CORE_RETURN = 1'b0; ack_dly = 4'h0;
        // Edges from ack to load seen, and from return pulse to done seen
        err_total = 0; n_checks = 0; lat_ref = 6; ret_ref = 5;
        repeat (5) @(posedge REF_CLK);
        RST_N <= 1'b1;
        @(posedge REF_CLK);
        t_reset;
        t_setup;
        t_order;
        t_block;
        t_alt;
        t_evt;
        finish_test;
    end
endmodule // test_vectored_interrupt_controller
bind vic_top vic_assertions u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE), .HSEL(HSEL), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CORE_IRQ(CORE_IRQ),
    .CORE_ACK(CORE_ACK), .CORE_VECTOR(CORE_VECTOR), .CORE_LEVEL(CORE_LEVEL), .CORE_VEC_ADDR(CORE_VEC_ADDR),
    .CORE_PC(CORE_PC), .CORE_PC_LOAD(CORE_PC_LOAD));
`default_nettype wire

// file: test/vic_assertions.sv
// Concurrent checks on the ports of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_assertions (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic CORE_IRQ,
    input wire logic CORE_ACK,
    input wire logic [7:0] CORE_VECTOR,
    input wire logic [3:0] CORE_LEVEL,
    input wire logic [23:0] CORE_VEC_ADDR,
    input wire logic [23:0] CORE_PC,
    input wire logic CORE_PC_LOAD
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N || !CE);
    sequence s_rd;
        HSEL && HTRANS[1] && HREADY && !HWRITE;
    endsequence
    sequence s_one_wait;
        !HREADYOUT ##1 HREADYOUT;
    endsequence
    sequence s_entry;
        !CORE_IRQ ##0 (!CORE_PC_LOAD)[*5] ##1 CORE_PC_LOAD;
    endsequence
    bus_okay_a: assert property (HRESP == 1'b0) else $error("bus response not okay");
    read_wait_a: assert property (s_rd |=> s_one_wait) else $error("read wait wrong");
    write_nowait_a: assert property (HSEL && HTRANS[1] && HREADY && HWRITE |=> HREADYOUT)
        else $error("write stalled");
    irq_hold_a: assert property (CORE_IRQ && !CORE_ACK |=> CORE_IRQ && $stable(CORE_VECTOR)
        && $stable(CORE_PC)) else $error("request changed before ack");
    entry_time_a: assert property (CORE_IRQ && CORE_ACK |=> s_entry) else $error("entry time");
    load_pulse_a: assert property (CORE_PC_LOAD |=> !CORE_PC_LOAD) else $error("load too long");
    vec_addr_a: assert property (CORE_IRQ |-> CORE_VEC_ADDR == 24'h4 + {15'h0, CORE_VECTOR, 1'b0}
        || CORE_VEC_ADDR == 24'h104 + {15'h0, CORE_VECTOR, 1'b0}) else $error("entry address");
    trap_level_a: assert property (CORE_IRQ && CORE_VECTOR < 8'h08
        |-> CORE_LEVEL == 4'hf - CORE_VECTOR[3:0]) else $error("trap level");
    src_level_a: assert property (CORE_IRQ && CORE_VECTOR > 8'h07
        |-> CORE_LEVEL inside {[1:7]}) else $error("source level");
    reset_clear_a: assert property ($rose(RST_N) |-> CORE_PC == 24'h0 && !CORE_IRQ)
        else $error("not clear after reset");
endmodule // vic_assertions
`default_nettype wire

// file: test/vic_core_model.sv
// Processor core model: acknowledges requests, takes the handler address
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic irq,
    input wire logic pc_load,
    input wire logic [23:0] pc,
    input wire logic [3:0] dly,
    output var logic ack,
    output var logic [23:0] pc_taken
);
    logic [3:0] cnt_r;
    // ----------------------------------------
    // Acknowledge after dly+1 cycles of request
    // ----------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            cnt_r <= 4'h0;
            pc_taken <= 24'h0;
        end else begin
            if (pc_load) pc_taken <= pc;
            if (ack) begin
                ack <= 1'b0;
                cnt_r <= 4'h0;
            end else if (irq) begin
                if (cnt_r >= dly) ack <= 1'b1;
                else cnt_r <= cnt_r + 4'h1;
            end else cnt_r <= 4'h0;
        end
    end
endmodule // vic_core_model
`default_nettype wire
